// ---- adc_consts.vh ----
// Constants for the axis digital command decoder.
// Included by the decoder; holds definitions only.
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

// Operating modes
`define ADC_MODE_MONO       2'h1
`define ADC_MODE_BISTABLE   2'h2
`define ADC_MODE_RESET      2'h1

// Mode 1 variants
`define ADC_VAR_HOLD        2'h0
`define ADC_VAR_NORM_RET    2'h1
`define ADC_VAR_RESET       2'h0

// APB register byte offsets
`define ADC_REG_CTRL        12'h000
`define ADC_REG_STATUS      12'h004
`define ADC_REG_IRQ_STAT    12'h008
`define ADC_REG_IRQ_MASK    12'h00C
`define ADC_REG_STROKE      12'h010

// Control register fields
`define ADC_CTRL_VAR_LSB    0
`define ADC_CTRL_MODE_LSB   4
`define ADC_CTRL_ENDSENSE   8

// Interrupt bits
`define ADC_IRQ_ERR         0
`define ADC_IRQ_TEACH_DONE  1
`define ADC_IRQ_AT_END      2
`define ADC_IRQ_BITS        3

// Motion states
`define ADC_ST_HOLD         3'h0
`define ADC_ST_EXTEND       3'h1
`define ADC_ST_RETRACT      3'h2
`define ADC_ST_TEACH_A      3'h3
`define ADC_ST_TEACH_B      3'h4
`define ADC_ST_DEPOWER      3'h5
`define ADC_ST_ERROR        3'h6

`endif

// ---- adc_decoder.v ----
// Command decoder for an electric linear axis with discrete inputs.
// Assumes asynchronous command pins, end switches and a thermal trip input;
// registers reached over APB on sys_clk.
// Operation
// (RL1) Two modes: monostable family or bistable
// (RL2) Mode one after reset
// (RL3) Hold-anywhere stroke stops at any position
// (RL4) No command: stop and keep regulating
// (RL5) Extend, retract or brake from two inputs
// (RL6) Retract plus teach: teach run retract first
// (RL7) Extend plus teach: teach run extend first
// (RL8) Controller never asserts extend and retract
// (RL9) Teach alone: depower, stay ready
// (RL10) Teach alone also clears errors
// (RL11) Normally retracted: extend input picks end
// (RL12) Normally retracted teach: retract first
// (RL13) Controller avoids extend with teach there
// (RL14) Thermal trip: drop ready, enter error
// (RL15) Depower only in bistable or hold-anywhere
// (RL16) Controller changes mode by power cycle; the code takes a new variant from any CTRL write at once, and a new mode when the write names mode 1 or 2
// (RL17) End outputs only at matching end
// (RL18) Ready while operational and error free
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "adc_consts.vh"

module adc_decoder #(
  parameter STROKE_W = 16                       // Width of learned stroke counter
) (
  // Clock and reset
  input  wire                sys_clk,
  input  wire                reset,
  // Command pins from the controller
  input  wire                extend_cmd_in,
  input  wire                retract_cmd_in,
  input  wire                teach_clear_depower_in,
  input  wire                depower_request_in,
  // Mechanical sensing
  input  wire                end_ext_sw,
  input  wire                end_ret_sw,
  input  wire                thermal_trip,
  // Status pins to the controller
  output reg                 ready_out,
  output reg                 at_extended_end_out,
  output reg                 at_retracted_end_out,
  // Drive commands to the motor stage
  output reg                 drive_extend,
  output reg                 drive_retract,
  output reg                 drive_slow,
  output reg                 regulate_en,
  output reg                 power_en,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  // Interrupt
  output reg                 irq
);

  // Two-stage synchronisers for all pin inputs
  reg  [6:0]          sync_a;                   // First stage, read only by second
  reg  [6:0]          sync_b;                   // Second stage, safe to use
  wire                ext_i  = sync_b[0];
  wire                ret_i  = sync_b[1];
  wire                tch_i  = sync_b[2];
  wire                dep_i  = sync_b[3];
  wire                sw_e   = sync_b[4];
  wire                sw_r   = sync_b[5];
  wire                therm  = sync_b[6];

  // Synchroniser chain
  always @(posedge sys_clk) begin
    if (reset) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= {thermal_trip, end_ret_sw, end_ext_sw, depower_request_in,
                 teach_clear_depower_in, retract_cmd_in, extend_cmd_in};
      sync_b <= sync_a;
    end
  end

  // Configuration and state
  reg  [1:0]          op_mode;                  // Operating mode
  reg  [1:0]          variant;                  // Mode 1 variant
  reg  [2:0]          state;                    // Motion state
  reg  [2:0]          next_state;
  reg                 teach_ext_first;          // Teach run direction
  reg  [STROKE_W-1:0] stroke_cnt;               // Counts cycles during teach leg
  reg  [STROKE_W-1:0] stroke;                   // Learned stroke
  reg  [`ADC_IRQ_BITS-1:0] irq_stat;            // Sticky events
  reg  [`ADC_IRQ_BITS-1:0] irq_mask;            // Interrupt enables
  reg                 at_end_d;                 // Previous end indication

  // Decode of the pin command for the active variant
  function [2:0] adc_decode;
    input [1:0] mode;
    input [1:0] var_sel;
    input       e;
    input       r;
    input       t;
    input       dep;
    begin
      adc_decode = `ADC_ST_HOLD;
      if (mode == `ADC_MODE_MONO && var_sel == `ADC_VAR_NORM_RET) begin
        // Single-input variant, extend alone picks the end [RL11]
        if (!t)
          adc_decode = e ? `ADC_ST_EXTEND : `ADC_ST_RETRACT;     // [RL11]
        else if (!e)
          adc_decode = `ADC_ST_TEACH_A;                          // [RL12]
        else
          adc_decode = `ADC_ST_HOLD;          // Undefined pair, stay put [RL13]
      end else begin
        // Hold-anywhere decode, bistable shares it here [RL1]
        case ({e, r, t})
          3'h4:    adc_decode = `ADC_ST_EXTEND;                  // [RL5]
          3'h2:    adc_decode = `ADC_ST_RETRACT;                 // [RL5]
          3'h3:    adc_decode = `ADC_ST_TEACH_A;                 // [RL6]
          3'h5:    adc_decode = `ADC_ST_TEACH_A;                 // [RL7]
          3'h1:    adc_decode = `ADC_ST_DEPOWER;                 // [RL9]
          default: adc_decode = `ADC_ST_HOLD;  // Stop or illegal pair [RL4] [RL8]
        endcase
        if (dep && adc_decode == `ADC_ST_HOLD)
          adc_decode = `ADC_ST_DEPOWER;                          // [RL15]
      end
    end
  endfunction

  wire [2:0] cmd_state = adc_decode(op_mode, variant, ext_i, ret_i, tch_i, dep_i);
  wire       clear_cmd = tch_i && !ext_i && !ret_i;              // [RL10]

  // Next state of the motion sequencer
  always @* begin
    next_state = state;
    case (state)
      `ADC_ST_ERROR: begin
        if (clear_cmd && !therm)
          next_state = `ADC_ST_DEPOWER;                          // [RL10]
      end
      `ADC_ST_TEACH_A: begin
        // First leg toward the chosen end
        if (teach_ext_first ? sw_e : sw_r)
          next_state = `ADC_ST_TEACH_B;                          // [RL6] [RL7]
      end
      `ADC_ST_TEACH_B: begin
        // Second leg measures the stroke
        if (teach_ext_first ? sw_r : sw_e)
          next_state = `ADC_ST_HOLD;
      end
      default: begin
        // Any new command interrupts the stroke [RL3]
        next_state = cmd_state;
      end
    endcase
    if (therm)
      next_state = `ADC_ST_ERROR;                                // [RL14]
  end

  // Sequencer, teach bookkeeping and outputs
  always @(posedge sys_clk) begin
    if (reset) begin
      state                <= `ADC_ST_HOLD;
      teach_ext_first      <= 1'b0;
      stroke_cnt           <= {STROKE_W{1'b0}};
      stroke               <= {STROKE_W{1'b0}};
      ready_out            <= 1'b0;
      at_extended_end_out  <= 1'b0;
      at_retracted_end_out <= 1'b0;
      drive_extend         <= 1'b0;
      drive_retract        <= 1'b0;
      drive_slow           <= 1'b0;
      regulate_en          <= 1'b0;
      power_en             <= 1'b0;
    end else begin
      state <= next_state;
      // Latch teach direction on entry
      if (state != `ADC_ST_TEACH_A && next_state == `ADC_ST_TEACH_A)
        teach_ext_first <= ext_i;                                // [RL7]
      // Count second leg, store on completion
      if (state == `ADC_ST_TEACH_A)
        stroke_cnt <= {STROKE_W{1'b0}};
      else if (state == `ADC_ST_TEACH_B)
        stroke_cnt <= stroke_cnt + 1'b1;
      if (state == `ADC_ST_TEACH_B && next_state == `ADC_ST_HOLD)
        stroke <= stroke_cnt;                                    // [RL6] [RL12]
      // Drive decode from the next state
      drive_extend  <= next_state == `ADC_ST_EXTEND ||
                       (next_state == `ADC_ST_TEACH_A && (state == `ADC_ST_TEACH_A
                        ? teach_ext_first : ext_i)) ||
                       (next_state == `ADC_ST_TEACH_B && !teach_ext_first);
      drive_retract <= next_state == `ADC_ST_RETRACT ||
                       (next_state == `ADC_ST_TEACH_A && !(state == `ADC_ST_TEACH_A
                        ? teach_ext_first : ext_i)) ||
                       (next_state == `ADC_ST_TEACH_B && teach_ext_first);
      drive_slow    <= next_state == `ADC_ST_TEACH_A || next_state == `ADC_ST_TEACH_B;
      // Regulation holds position unless depowered or failed
      regulate_en   <= next_state != `ADC_ST_DEPOWER && next_state != `ADC_ST_ERROR; // [RL4]
      power_en      <= next_state != `ADC_ST_DEPOWER && next_state != `ADC_ST_ERROR; // [RL9]
      ready_out     <= next_state != `ADC_ST_ERROR;              // [RL18] [RL9]
      // End indications follow the switches
      at_extended_end_out  <= sw_e && !sw_r;                     // [RL17]
      at_retracted_end_out <= sw_r && !sw_e;                     // [RL17]
    end
  end

  // APB access decode; a write lands only on the edge that sees pready high,
  // so the master and the slave agree on the one edge that completes it
  wire       apb_acc = psel && penable && !pready;
  wire       apb_wr  = psel && penable && pready && pwrite;
  wire       addr_ok = paddr == `ADC_REG_CTRL || paddr == `ADC_REG_STATUS ||
                       paddr == `ADC_REG_IRQ_STAT || paddr == `ADC_REG_IRQ_MASK ||
                       paddr == `ADC_REG_STROKE;
  wire [`ADC_IRQ_BITS-1:0] events;
  wire       at_end = at_extended_end_out || at_retracted_end_out;
  assign events = {at_end && !at_end_d,
                   state == `ADC_ST_TEACH_B && next_state == `ADC_ST_HOLD,
                   state != `ADC_ST_ERROR && next_state == `ADC_ST_ERROR};

  // Registers, one-wait-state answer, interrupt
  always @(posedge sys_clk) begin
    if (reset) begin
      op_mode  <= `ADC_MODE_RESET;                               // [RL2]
      variant  <= `ADC_VAR_RESET;
      irq_stat <= {`ADC_IRQ_BITS{1'b0}};
      irq_mask <= {`ADC_IRQ_BITS{1'b0}};
      at_end_d <= 1'b0;
      prdata   <= 32'h00000000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      at_end_d <= at_end;
      pready   <= apb_acc;
      pslverr  <= apb_acc && !addr_ok;
      // Control writes; only the two documented modes accepted
      if (apb_wr && paddr == `ADC_REG_CTRL) begin
        if (pwdata[`ADC_CTRL_MODE_LSB+1:`ADC_CTRL_MODE_LSB] == `ADC_MODE_MONO ||
            pwdata[`ADC_CTRL_MODE_LSB+1:`ADC_CTRL_MODE_LSB] == `ADC_MODE_BISTABLE)
          op_mode <= pwdata[`ADC_CTRL_MODE_LSB+1:`ADC_CTRL_MODE_LSB];  // [RL1]
        variant <= pwdata[`ADC_CTRL_VAR_LSB+1:`ADC_CTRL_VAR_LSB];
      end
      // Sticky status: set wins over write-one clear
      if (apb_wr && paddr == `ADC_REG_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[`ADC_IRQ_BITS-1:0]) | events;
      else
        irq_stat <= irq_stat | events;
      if (apb_wr && paddr == `ADC_REG_IRQ_MASK)
        irq_mask <= pwdata[`ADC_IRQ_BITS-1:0];
      irq <= |(irq_stat & irq_mask);
      // Read data
      prdata <= 32'h00000000;
      if (apb_acc && !pwrite) begin
        case (paddr)
          `ADC_REG_CTRL:     prdata <= {26'h0, op_mode, 2'h0, variant};
          `ADC_REG_STATUS:   prdata <= {23'h0, power_en, regulate_en, ready_out,
                                        at_retracted_end_out, at_extended_end_out,
                                        therm, state};
          `ADC_REG_IRQ_STAT: prdata <= {29'h0, irq_stat};
          `ADC_REG_IRQ_MASK: prdata <= {29'h0, irq_mask};
          `ADC_REG_STROKE:   prdata <= {{(32-STROKE_W){1'b0}}, stroke};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // adc_decoder

// ---- adc_monitor.sv ----
// Port checker for the axis command decoder.
// Assumes one clock, sys_clk, and a synchronous active-high reset.
`timescale 1ns/1ns
module adc_monitor (
  // Clock and reset
  input wire        sys_clk, reset,
  // Command pins and sensing
  input wire        extend_cmd_in, retract_cmd_in, teach_clear_depower_in,
  input wire        depower_request_in, end_ext_sw, end_ret_sw, thermal_trip,
  // Status and drive
  input wire        ready_out, at_extended_end_out, at_retracted_end_out,
  input wire        drive_extend, drive_retract, drive_slow, power_en,
  // Register bus
  input wire        psel, penable, pwrite, pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Decoded pin patterns
  wire any_e = extend_cmd_in && !retract_cmd_in;
  wire quiet = !teach_clear_depower_in && !depower_request_in;
  wire cmd_e = any_e && quiet;
  wire cmd_r = retract_cmd_in && !extend_cmd_in && quiet;
  wire cmd_0 = !extend_cmd_in && !retract_cmd_in && quiet;
  wire cmd_t = teach_clear_depower_in && !extend_cmd_in && !retract_cmd_in;
  wire run_ok = !thermal_trip && ready_out && !drive_slow; // Healthy, no teach leg
  reg  nr_var;                                              // Normally retracted chosen
  // Track the variant field on the edge the slave takes a write
  always @(posedge sys_clk) begin
    if (reset) nr_var <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 12'h000)
      nr_var <= (pwdata[1:0] == 2'h1);
  end
  a_ext_cmd_drive: assert property (
    (cmd_e && run_ok && !end_ext_sw)[*5] |-> drive_extend) else $error("extend not driven");
  a_ret_cmd_drive: assert property (
    (cmd_r && run_ok && !end_ret_sw)[*5] |-> drive_retract) else $error("retract not driven");
  a_idle_stops: assert property (
    (cmd_0 && run_ok && !nr_var)[*5] |-> !drive_extend && !drive_retract)
    else $error("axis moves without command");
  a_teach_depower: assert property (
    (cmd_t && run_ok && !nr_var)[*6] |-> !power_en) else $error("power kept on teach only");
  a_heat_drops_ready: assert property (
    thermal_trip[*6] |-> !ready_out) else $error("ready kept on thermal trip");
  a_ends_exclusive: assert property (
    !(at_extended_end_out && at_retracted_end_out)) else $error("both end outputs high");
  a_ext_end_source: assert property (
    !end_ext_sw[*4] |-> !at_extended_end_out) else $error("extended end without switch");
  a_ret_end_source: assert property (
    !end_ret_sw[*4] |-> !at_retracted_end_out) else $error("retracted end without switch");
  a_bus_answer: assert property (
    psel && penable && !pready |=> pready) else $error("no answer on access");
  a_bus_one_cycle: assert property (
    pready |=> !pready) else $error("ready longer than one cycle");
endmodule // adc_monitor

bind adc_decoder adc_monitor u_adc_monitor (.sys_clk, .reset, .extend_cmd_in,
  .retract_cmd_in, .teach_clear_depower_in, .depower_request_in, .end_ext_sw, .end_ret_sw,
  .thermal_trip, .ready_out, .at_extended_end_out, .at_retracted_end_out, .drive_extend,
  .drive_retract, .drive_slow, .power_en, .psel, .penable, .pwrite, .pready, .paddr, .pwdata);

// ---- adc_far_side.sv ----
// Far side: controller pins plus slide mechanics with end switches.
// Assumes the bench changes requests just after a sys_clk edge.
`timescale 1ns/1ns
module adc_far_side #(
  parameter POS_MAX = 100 // Travel in motion steps
) (
  // Clock, reset, bench requests and variant in use
  input  wire sys_clk, reset, req_e, req_r, req_t, req_dep, nr_sel,
  // Drive from the decoder
  input  wire drive_extend, drive_retract, power_en,
  // Pins toward the decoder
  output wire extend_cmd_in, retract_cmd_in, teach_clear_depower_in,
  output wire depower_request_in, end_ext_sw, end_ret_sw
);
  integer pos; // Slide position
  // Never both directions at once no extend with teach there
  assign extend_cmd_in = req_e & ~req_r & ~(nr_sel & req_t);
  assign retract_cmd_in = req_r & ~req_e;
  assign teach_clear_depower_in = req_t;
  assign depower_request_in = req_dep;
  // Switches close only at the ends of travel
  assign end_ext_sw = (pos == POS_MAX);
  assign end_ret_sw = (pos == 0);
  // One step per cycle while powered and driven
  always @(posedge sys_clk) begin
    if (reset) pos <= POS_MAX / 2;
    else if (power_en && drive_extend && pos < POS_MAX) pos <= pos + 1;
    else if (power_en && drive_retract && pos > 0) pos <= pos - 1;
  end
endmodule // adc_far_side

// ---- adc_decoder_tb.sv ----
// Self-checking bench for the axis command decoder.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/1ns
module adc_decoder_tb;
  reg         sys_clk, reset, thermal_trip, nr_sel;     // Clock, reset, heat, variant
  reg         req_e, req_r, req_t, req_dep;             // Requested pin levels
  reg         psel, penable, pwrite;                    // Bus request
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;                               // Write data, read result
  wire [31:0] prdata;
  wire        pready, pslverr, irq, ready_out, at_extended_end_out, at_retracted_end_out;
  wire        drive_extend, drive_retract, drive_slow, regulate_en, power_en;
  wire        extend_cmd_in, retract_cmd_in, teach_clear_depower_in, depower_request_in;
  wire        end_ext_sw, end_ret_sw;
  integer     n_errors, num_checks, cyc, i, j;
  reg  [7:0]  lf;                                       // Random state
  adc_decoder u_adc_decoder (.sys_clk, .reset, .extend_cmd_in, .retract_cmd_in,
    .teach_clear_depower_in, .depower_request_in, .end_ext_sw, .end_ret_sw, .thermal_trip,
    .ready_out, .at_extended_end_out, .at_retracted_end_out, .drive_extend, .drive_retract,
    .drive_slow, .regulate_en, .power_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq);
  adc_far_side u_adc_far_side (.sys_clk, .reset, .req_e, .req_r, .req_t, .req_dep, .nr_sel,
    .drive_extend, .drive_retract, .power_en, .extend_cmd_in, .retract_cmd_in,
    .teach_clear_depower_in, .depower_request_in, .end_ext_sw, .end_ret_sw);
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
  task final_report;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected {extend, retract, slow, regulate, power} for a settled command
  function [4:0] exp_drive(input nr, input [3:0] c);
    begin
      if (nr) exp_drive = c[3] ? 5'h13 : 5'h0B;
      else if (c[1] || c[0]) exp_drive = 5'h00;
      else if (c[3]) exp_drive = 5'h13;
      else if (c[2]) exp_drive = 5'h0B;
      else exp_drive = 5'h03;
    end
  endfunction
  // One bus transfer; waits for the slave's answer
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      i = 0;
      do begin
        @(posedge sys_clk);
        i = i + 1;
      end while (pready !== 1'b1 && i < 20);
      rd = pslverr ? (prdata | 32'h8000_0000) : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Apply {extend, retract, teach, depower} and compare settled drive
  task cmd(input [3:0] c);
    begin
      @(posedge sys_clk);
      {req_e, req_r, req_t, req_dep} <= c;
      repeat (5) @(posedge sys_clk);
      chk({drive_extend, drive_retract, drive_slow, regulate_en, power_en},
        exp_drive(nr_sel, c));
      chk(ready_out, 1'b1);
    end
  endtask
  // Teach run, extend first when ef is set
  task teach(input ef);
    begin
      @(posedge sys_clk);
      {req_e, req_r, req_t} <= {ef, ~ef & ~nr_sel, 1'b1};
      repeat (5) @(posedge sys_clk);
      chk({drive_extend, drive_retract, drive_slow}, {ef, ~ef, 1'b1});
      {req_e, req_r, req_t} <= {nr_sel, 2'b00};
      for (j = 0; j < 400 && drive_slow === 1'b1; j = j + 1) @(posedge sys_clk);
      repeat (5) @(posedge sys_clk);
      chk({at_extended_end_out, at_retracted_end_out}, {~ef, ef});
      apb(1'b0, 12'h010, 32'h0);
      chk(rd >= 100 && rd <= 108, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[1], 1'b1);
      $display("teach run done");
    end
  endtask
  initial begin
    {reset, thermal_trip, nr_sel, req_e, req_r, req_t, req_dep} = 7'h40;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    {n_errors, num_checks, cyc} = 0;
    lf = 8'h0A;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({ready_out, regulate_en, power_en}, 3'h7);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h10);
    for (i = 0; i < 8; i = i + 1) begin
      lf = lfsr(lf);
      cmd({lf[1:0] == 2'h0, lf[1:0] == 2'h1, lf[1:0] == 2'h3, lf[1:0] == 2'h2 && lf[2]});
    end
    $display("hold-anywhere decode done");
    apb(1'b1, 12'h00C, 32'h2);
    teach(1'b1);
    chk(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h7);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0);
    apb(1'b1, 12'h00C, 32'h0);
    cmd(4'h8);
    cmd(4'h8);
    teach(1'b0);
    chk(irq, 1'b0);
    $display("interrupt done");
    thermal_trip <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(ready_out, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b1);
    thermal_trip <= 1'b0;
    cmd(4'h2);
    $display("thermal error done");
    cmd(4'h0); // Teach pin low before the variant changes
    apb(1'b1, 12'h000, 32'h11); // Variant change stands in for the power cycle
    nr_sel <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h11);
    cmd(4'h8);
    cmd(4'h0);
    cmd(4'h1);
    teach(1'b0);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h8000_0000);
    $display("normally retracted done");
    final_report;
  end
endmodule // adc_decoder_tb
